// *** common/flash_pkg.sv ***
// shared constants and types for the serial flash status/read link
package flash_pkg;
  // opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK   = 8'h04;
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OP_STATUS_STORE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OP_OTP_ENTER    = 8'h3A;
  localparam logic [7:0] OP_WIPE_A       = 8'hC7;
  localparam logic [7:0] OP_WIPE_B       = 8'h60;
  // status word layout
  localparam int ST_BUSY    = 0;
  localparam int ST_PERMIT  = 1;
  localparam int ST_LVL_LO  = 2;
  localparam int ST_LVL_HI  = 4;
  localparam int ST_LOCK    = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // frame bit counts
  localparam logic [5:0] BITS_CMD  = 6'h08;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] BITS_WSR  = 6'h10;
  // array geometry
  localparam int ADDR_W   = 24;
  localparam int ARRAY_AW = 17;
  localparam logic [23:0] ARRAY_TOP = 24'h01FFFF;
  // timing
  localparam int REF_CLK_MHZ     = 200;
  localparam int STATUS_WRITE_NS = 10000;
  localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS * REF_CLK_MHZ) / 1000;
  localparam int SCLK_PERIOD_NS  = 160;
  localparam int SCLK_HALF_CYC   = (SCLK_PERIOD_NS * REF_CLK_MHZ) / 2000;
  // host register map (byte addresses)
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TX   = 12'h004;
  localparam logic [11:0] REG_RX   = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00C;
  localparam logic [11:0] REG_PINS = 12'h010;
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_LEN_LSB = 8;
  localparam int STAT_BUSY    = 0;
  localparam int PINS_GUARD   = 0;
  localparam logic [31:0] TX_RESET = 32'h00000000;
  typedef enum logic [2:0] {M_OFF, M_CMD, M_TAIL, M_STAT, M_ADDR, M_DATA, M_IGNORE} dev_mode_t;
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TRAIL, H_GAP} host_phase_t;
endpackage

// *** common/flash_link_if.sv ***
// serial link between the flash device end and the host controller end
`timescale 1ns/1ps
interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic guard_n;
  logic so_o;
  logic so_oe_n;
  logic so;
  // output line pulled high while the device does not drive it
  assign so = so_oe_n ? 1'b1 : so_o;
  modport dev (input cs_n, input sclk, input mosi, input guard_n, output so_o, output so_oe_n);
  modport host (output cs_n, output sclk, output mosi, output guard_n, input so);
endinterface

// *** core/pin_sync.sv ***
// two-stage synchroniser with edge detection behind the second stage
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;
  sync_t sync_reg;
  sync_t sync_next;

  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = din;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync_reg <= '{RESET_VAL, RESET_VAL, RESET_VAL};
    end else if (ce) begin
      sync_reg <= sync_next;
    end
  end

  assign level = sync_reg.s2;
  assign rise  = sync_reg.s2 & ~sync_reg.s3;
  assign fall  = ~sync_reg.s2 & sync_reg.s3;
endmodule

// *** core/flash_device.sv ***
// serial flash device end: status word, write latch, protection and array read
// Functional notes
// R1 - opcode 04h clears latch or leaves OTP
// R2 - latch clears at reset and cycle completion
// R3 - opcode 05h streams status byte repeatedly, anytime
// R4 - bit 0 shows busy cycle, volatile
// R5 - bit 1 latch; cleared latch refuses writes
// R6 - bits 2-4 non-volatile protection level
// R7 - protection bits change only outside hardware lock
// R8 - whole erase only with zero protection level
// R9 - bits 5 and 6 read zero
// R10 - host masks reserved bits when testing status
// R11 - lock bit plus low guard pin locks status
// R12 - in OTP mode bit 7 seals sector
// R13 - OTP status write ignores data, sets seal
// R14 - host seals OTP sector before leaving mode
// R15 - status write 01h plus byte needs latch
// R16 - status write keeps bits 6,5,1,0
// R17 - status write discarded unless ends after byte
// R18 - status write runs timed cycle, busy, clears latch
// R19 - read 03h, 24-bit address, data on falls
// R20 - read address increments and wraps to zero
// R21 - read ends at any bit on deselect
// R22 - read refused while a cycle runs
// R23 - opcode 06h sets the write latch
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module flash_device (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        EXT_BUSY,
  input  wire logic        EXT_DONE,
  input  wire logic        ARRAY_WE,
  input  wire logic [16:0] ARRAY_WADDR,
  input  wire logic [7:0]  ARRAY_WDATA,
  flash_link_if.dev        LINK,
  output logic      [7:0]  STATUS_WORD,
  output logic             HW_LOCK,
  output logic             OTP_MODE,
  output logic             CHIP_ERASE_GO
);
  localparam int ARRAY_BYTES = 1 << flash_pkg::ARRAY_AW;
  localparam logic [11:0] WSR_CYC = 12'(flash_pkg::STATUS_WRITE_CYC);

  typedef struct packed {
    flash_pkg::dev_mode_t mode;
    logic [7:0]  opcode;
    logic [7:0]  shin;
    logic [5:0]  cnt;
    logic [23:0] addr;
    logic [7:0]  tx;
    logic [2:0]  obit;
    logic        so;
    logic        so_oe_n;
    logic        permit;
    logic [2:0]  level;
    logic        lock_bit;
    logic        otp;
    logic        seal;
    logic        wsr_busy;
    logic [11:0] tmr;
    logic [7:0]  pend;
    logic        pend_otp;
    logic [7:0]  status_out;
    logic        lock_out;
    logic        erase_go;
  } dev_state_t;

  dev_state_t st_reg;
  dev_state_t st_next;
  logic [7:0] mem [0:ARRAY_BYTES-1];
  logic [3:0] pin_level;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic       cs_n_s;
  logic       si_s;
  logic       guard_n_s;
  logic       busy_now;
  logic       hw_lock;
  logic [7:0] status_now;
  logic [23:0] addr_load;
  logic [23:0] addr_step;

  function automatic logic [5:0] sat_inc(input logic [5:0] v);
    return (v == 6'h3F) ? v : 6'(v + 6'h01);
  endfunction

  function automatic logic [23:0] next_addr(input logic [23:0] a);
    return (a >= flash_pkg::ARRAY_TOP) ? 24'h000000 : 24'(a + 24'h000001);
  endfunction

  function automatic logic [16:0] mem_idx(input logic [23:0] a);
    return a[flash_pkg::ARRAY_AW-1:0];
  endfunction

  // cs_n, sclk, mosi, guard_n
  pin_sync #(.W(4), .RESET_VAL(4'h9)) u_sync (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .ce      (CE),
    .din     ({LINK.cs_n, LINK.sclk, LINK.mosi, LINK.guard_n}),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  assign cs_n_s    = pin_level[3];
  assign si_s      = pin_level[1];
  assign guard_n_s = pin_level[0];

  // array contents come from the program/erase logic elsewhere
  always_ff @(posedge REF_CLK) begin
    if (CE && ARRAY_WE) begin
      mem[ARRAY_WADDR] <= ARRAY_WDATA;
    end
  end

  assign busy_now  = st_reg.wsr_busy | EXT_BUSY; // R4
  assign hw_lock   = st_reg.lock_bit & ~guard_n_s; // R11
  assign addr_load = {st_reg.addr[22:0], si_s};
  assign addr_step = next_addr(st_reg.addr); // R20

  always_comb begin
    status_now = flash_pkg::STATUS_RESET;
    status_now[flash_pkg::ST_BUSY] = busy_now; // R4
    status_now[flash_pkg::ST_PERMIT] = st_reg.permit; // R5
    status_now[flash_pkg::ST_LVL_HI:flash_pkg::ST_LVL_LO] = st_reg.level; // R6
    status_now[flash_pkg::ST_LOCK] = st_reg.otp ? st_reg.seal : st_reg.lock_bit; // R12
  end // R9

  always_comb begin
    st_next = st_reg;
    st_next.erase_go = 1'b0;
    st_next.status_out = status_now;
    st_next.lock_out = hw_lock;
    if (EXT_DONE) begin
      st_next.permit = 1'b0; // R2
    end
    // ==========================================================
    // self-timed status write cycle
    if (st_reg.wsr_busy) begin
      st_next.tmr = 12'(st_reg.tmr - 12'h001);
      if (st_reg.tmr == 12'h001) begin
        st_next.wsr_busy = 1'b0;
        st_next.permit = 1'b0; // R18
        if (st_reg.pend_otp) begin
          st_next.seal = 1'b1; // R13
        end else begin
          st_next.lock_bit = st_reg.pend[flash_pkg::ST_LOCK];
          st_next.level = st_reg.pend[flash_pkg::ST_LVL_HI:flash_pkg::ST_LVL_LO]; // R16
        end
      end
    end
    // ==========================================================
    // serial frame
    if (pin_fall[3]) begin
      st_next.mode = flash_pkg::M_CMD;
      st_next.cnt = 6'h00;
      st_next.so_oe_n = 1'b1;
    end else if (pin_rise[3]) begin
      st_next.mode = flash_pkg::M_OFF;
      st_next.so_oe_n = 1'b1; // R21
      if (st_reg.cnt == flash_pkg::BITS_CMD) begin // R17
        unique case (st_reg.opcode)
          flash_pkg::OP_WRITE_UNLOCK: begin
            if (!busy_now) begin
              st_next.permit = 1'b1; // R23
            end
          end
          flash_pkg::OP_WRITE_LOCK: begin
            if (st_reg.otp) begin
              st_next.otp = 1'b0; // R1
            end else begin
              st_next.permit = 1'b0; // R1
            end
          end
          flash_pkg::OP_OTP_ENTER: begin
            st_next.otp = 1'b1;
          end
          flash_pkg::OP_WIPE_A, flash_pkg::OP_WIPE_B: begin
            if (st_reg.permit && !busy_now && st_reg.level == 3'h0) begin
              st_next.erase_go = 1'b1; // R8
            end
          end
          default: begin
          end
        endcase
      end
      if (st_reg.cnt == flash_pkg::BITS_WSR && st_reg.opcode == flash_pkg::OP_STATUS_STORE
          && st_reg.permit && !hw_lock && !busy_now) begin // R15 R7 R5 R17
        st_next.wsr_busy = 1'b1; // R18
        st_next.tmr = WSR_CYC;
        st_next.pend = st_reg.shin;
        st_next.pend_otp = st_reg.otp; // R13
      end
    end else if (!cs_n_s && pin_rise[2] && st_reg.mode != flash_pkg::M_OFF) begin
      st_next.shin = {st_reg.shin[6:0], si_s};
      st_next.cnt = sat_inc(st_reg.cnt);
      unique case (st_reg.mode)
        flash_pkg::M_CMD: begin
          if (st_reg.cnt == 6'(flash_pkg::BITS_CMD - 6'h01)) begin
            st_next.opcode = {st_reg.shin[6:0], si_s};
            st_next.obit = 3'h0;
            st_next.mode = flash_pkg::M_TAIL;
            if (st_next.opcode == flash_pkg::OP_STATUS_FETCH) begin
              st_next.mode = flash_pkg::M_STAT; // R3
              st_next.tx = status_now;
            end else if (st_next.opcode == flash_pkg::OP_ARRAY_READ) begin
              st_next.mode = busy_now ? flash_pkg::M_IGNORE : flash_pkg::M_ADDR; // R22
            end
          end
        end
        flash_pkg::M_ADDR: begin
          st_next.addr = addr_load; // R19
          if (st_reg.cnt == 6'(flash_pkg::BITS_ADDR - 6'h01)) begin
            st_next.mode = flash_pkg::M_DATA;
            st_next.tx = mem[mem_idx(addr_load)];
          end
        end
        default: begin
        end
      endcase
    end else if (!cs_n_s && pin_fall[2]
                 && (st_reg.mode == flash_pkg::M_STAT || st_reg.mode == flash_pkg::M_DATA)) begin
      st_next.so = st_reg.tx[7]; // R19
      st_next.so_oe_n = 1'b0;
      st_next.tx = {st_reg.tx[6:0], 1'b0};
      st_next.obit = 3'(st_reg.obit + 3'h1);
      if (st_reg.obit == 3'h7) begin
        if (st_reg.mode == flash_pkg::M_STAT) begin
          st_next.tx = status_now; // R3
        end else begin
          st_next.addr = addr_step; // R20
          st_next.tx = mem[mem_idx(addr_step)];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      st_reg <= '0; // R2
      st_reg.so_oe_n <= 1'b1;
      st_reg.mode <= flash_pkg::M_OFF;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  assign LINK.so_o     = st_reg.so;
  assign LINK.so_oe_n  = st_reg.so_oe_n;
  assign STATUS_WORD   = st_reg.status_out;
  assign HW_LOCK       = st_reg.lock_out;
  assign OTP_MODE      = st_reg.otp;
  assign CHIP_ERASE_GO = st_reg.erase_go;
endmodule

// *** core/flash_host.sv ***
// host controller end: APB registers drive framed serial transfers
`timescale 1ns/1ps
module flash_host (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  flash_link_if.host       LINK
);
  localparam logic [4:0] HALF_LAST = 5'(flash_pkg::SCLK_HALF_CYC - 1);

  typedef struct packed {
    flash_pkg::host_phase_t ph;
    logic [7:0]  op;
    logic [7:0]  len;
    logic [31:0] tx;
    logic [7:0]  rx;
    logic [39:0] sh;
    logic [10:0] bits;
    logic [4:0]  div;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        guard_n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } host_state_t;

  host_state_t hs_reg;
  host_state_t hs_next;
  logic        so_s;
  logic        setup;
  logic        commit;
  logic        busy;
  logic        half_done;

  pin_sync #(.W(1), .RESET_VAL(1'b1)) u_so_sync (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .ce      (CE),
    .din     (LINK.so),
    .level   (so_s),
    .rise    (),
    .fall    ()
  );

  assign setup     = PSEL & ~PENABLE;
  assign commit    = PSEL & PENABLE & hs_reg.pready & PWRITE;
  assign busy      = hs_reg.ph != flash_pkg::H_IDLE;
  assign half_done = hs_reg.div == HALF_LAST;

  always_comb begin
    hs_next = hs_reg;
    // ==========================================================
    // APB slave: one wait-free access phase
    hs_next.pready  = setup;
    hs_next.pslverr = 1'b0;
    if (setup) begin
      unique case (PADDR)
        flash_pkg::REG_CTRL: hs_next.prdata = {16'h0000, hs_reg.len, hs_reg.op};
        flash_pkg::REG_TX:   hs_next.prdata = hs_reg.tx;
        flash_pkg::REG_RX:   hs_next.prdata = {24'h000000, hs_reg.rx};
        flash_pkg::REG_STAT: hs_next.prdata = {31'h00000000, busy};
        flash_pkg::REG_PINS: hs_next.prdata = {31'h00000000, hs_reg.guard_n};
        default: begin
          hs_next.prdata  = 32'h00000000;
          hs_next.pslverr = 1'b1;
        end
      endcase
    end
    if (commit && PADDR == flash_pkg::REG_TX) begin
      hs_next.tx = PWDATA;
    end
    if (commit && PADDR == flash_pkg::REG_PINS) begin
      hs_next.guard_n = PWDATA[flash_pkg::PINS_GUARD];
    end
    // a new frame is refused while one is running
    if (commit && PADDR == flash_pkg::REG_CTRL && !busy && PWDATA[15:8] != 8'h00) begin
      hs_next.op   = PWDATA[flash_pkg::CTRL_OP_LSB +: 8];
      hs_next.len  = PWDATA[flash_pkg::CTRL_LEN_LSB +: 8];
      hs_next.sh   = {PWDATA[7:0], hs_reg.tx};
      hs_next.bits = 11'h000;
      hs_next.div  = 5'h00;
      hs_next.cs_n = 1'b0;
      hs_next.mosi = PWDATA[7];
      hs_next.ph   = flash_pkg::H_LOW;
    end
    // ==========================================================
    // serial clock divider and frame sequence
    if (busy) begin
      hs_next.div = half_done ? 5'h00 : 5'(hs_reg.div + 5'h01);
    end
    if (half_done) begin
      unique case (hs_reg.ph)
        flash_pkg::H_LOW: begin
          hs_next.sclk = 1'b1;
          hs_next.rx   = {hs_reg.rx[6:0], so_s};
          hs_next.ph   = flash_pkg::H_HIGH;
        end
        flash_pkg::H_HIGH: begin
          hs_next.sclk = 1'b0;
          hs_next.sh   = {hs_reg.sh[38:0], 1'b0};
          hs_next.mosi = hs_reg.sh[38];
          hs_next.bits = 11'(hs_reg.bits + 11'h001);
          if (11'(hs_reg.bits + 11'h001) == {hs_reg.len, 3'h0}) begin
            hs_next.ph = flash_pkg::H_TRAIL;
          end else begin
            hs_next.ph = flash_pkg::H_LOW;
          end
        end
        flash_pkg::H_TRAIL: begin
          hs_next.cs_n = 1'b1; // R17
          hs_next.ph   = flash_pkg::H_GAP;
        end
        flash_pkg::H_GAP: begin
          hs_next.ph = flash_pkg::H_IDLE;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      hs_reg         <= '0;
      hs_reg.ph      <= flash_pkg::H_IDLE;
      hs_reg.tx      <= flash_pkg::TX_RESET;
      hs_reg.cs_n    <= 1'b1;
      hs_reg.guard_n <= 1'b1;
    end else if (CE) begin
      hs_reg <= hs_next;
    end
  end

  assign PRDATA       = hs_reg.prdata;
  assign PREADY       = hs_reg.pready;
  assign PSLVERR      = hs_reg.pslverr;
  assign LINK.cs_n    = hs_reg.cs_n;
  assign LINK.sclk    = hs_reg.sclk;
  assign LINK.mosi    = hs_reg.mosi;
  assign LINK.guard_n = hs_reg.guard_n;
endmodule

// *** verif/flash_link_props.sv ***
// checker: timing of the serial link between the two ends
`timescale 1ns/1ps
module flash_link_props (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic so_o,
  input wire logic so_oe_n
);
  // ==========================================
  // high-phase counter of the serial clock
  logic [5:0] hi_cnt_reg;
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || !sclk) hi_cnt_reg <= 6'h00;
    else hi_cnt_reg <= hi_cnt_reg + 6'h01;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // ==========================================
  // sequences and properties
  sequence s_rise; $rose(sclk); endsequence
  sequence s_desel; cs_n [*6]; endsequence
  property p_idle_low; cs_n |-> !sclk; endproperty
  property p_sel_setup; $fell(cs_n) |-> !sclk [*8]; endproperty
  property p_mosi_hold; s_rise |-> ##1 $stable(mosi) [*8]; endproperty
  property p_so_hold; s_rise |-> ##1 $stable(so_o) [*8]; endproperty
  property p_half; $fell(sclk) |-> hi_cnt_reg == 6'(flash_pkg::SCLK_HALF_CYC); endproperty
  property p_gap; $rose(cs_n) |-> cs_n [*4]; endproperty
  property p_release; $rose(cs_n) |-> ##[1:6] so_oe_n; endproperty
  property p_quiet; s_desel |-> so_oe_n; endproperty
  property p_drive_low; $fell(so_oe_n) |-> !sclk && !cs_n; endproperty
  a_idle_low: assert property (p_idle_low) else $error("serial clock high while deselected");
  a_sel_setup: assert property (p_sel_setup) else $error("clock edge too soon after select");
  a_mosi_hold: assert property (p_mosi_hold) else $error("input line moved after rising clock");
  a_so_hold: assert property (p_so_hold) else $error("output line moved after rising clock");
  a_half: assert property (p_half) else $error("serial clock high phase wrong length");
  a_gap: assert property (p_gap) else $error("deselect gap too short");
  a_release: assert property (p_release) else $error("output not released after deselect");
  a_quiet: assert property (p_quiet) else $error("output driven while deselected");
  a_drive_low: assert property (p_drive_low) else $error("output driving began off a falling clock");
endmodule

// *** verif/serial_flash_status_and_read_bench.sv ***
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
module serial_flash_status_and_read_bench;
  typedef struct { string nm; logic [32:0] v; } note_t;
  logic        REF_CLK = 1'h0;
  logic        RESET_N = 1'h0;
  logic        CE = 1'h1;
  logic        EXT_BUSY = 1'h0;
  logic        EXT_DONE = 1'h0;
  logic        ARRAY_WE = 1'h0;
  logic [16:0] ARRAY_WADDR = 17'h00000;
  logic [7:0]  ARRAY_WDATA = 8'h00;
  logic        PSEL = 1'h0;
  logic        PENABLE = 1'h0;
  logic        PWRITE = 1'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [7:0]  STATUS_WORD;
  logic        HW_LOCK;
  logic        OTP_MODE;
  logic        CHIP_ERASE_GO;
  logic        rd_chk = 1'h0;
  logic [7:0]  a0;
  logic [7:0]  a1;
  logic [7:0]  d;
  logic [7:0]  st;
  note_t       exp_q[$];
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          erase_cnt = 0;
  always #2.5 REF_CLK = ~REF_CLK;
  flash_link_if link ();
  flash_device flash_device_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .CE(CE), .EXT_BUSY(EXT_BUSY),
    .EXT_DONE(EXT_DONE), .ARRAY_WE(ARRAY_WE), .ARRAY_WADDR(ARRAY_WADDR), .ARRAY_WDATA(ARRAY_WDATA),
    .LINK(link), .STATUS_WORD(STATUS_WORD), .HW_LOCK(HW_LOCK), .OTP_MODE(OTP_MODE), .CHIP_ERASE_GO(CHIP_ERASE_GO));
  flash_host flash_host_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LINK(link));
  flash_link_props flash_link_props_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .so_o(link.so_o), .so_oe_n(link.so_oe_n));
  // ==========================================
  // comparison, verdict, monitor
  task automatic cmp(string nm, logic [32:0] e, logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (exp_q.size() != 0) cmp("queue_left", 33'h000000000, 33'(exp_q.size()));
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (CHIP_ERASE_GO === 1'h1) erase_cnt <= erase_cnt + 1;
    if (PSEL && PENABLE && PREADY && rd_chk) begin
      if (exp_q.size() == 0) cmp("queue", 33'h000000000, 33'h1FFFFFFFF);
      else begin
        cmp(exp_q[0].nm, exp_q[0].v, {PSLVERR, PRDATA});
        void'(exp_q.pop_front());
      end
    end
    if (cyc > 90000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ==========================================
  // bus and frame tasks
  task automatic apb(logic w, logic [11:0] a, logic [31:0] wd, logic chk, output logic [31:0] rd);
    @(posedge REF_CLK);
    PSEL <= 1'h1; PWRITE <= w; PADDR <= a; PWDATA <= wd; PENABLE <= 1'h0; rd_chk <= chk;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    @(posedge REF_CLK);
    while (PREADY !== 1'h1) @(posedge REF_CLK);
    rd = PRDATA;
    PSEL <= 1'h0; PENABLE <= 1'h0; rd_chk <= 1'h0;
  endtask
  task automatic frame(logic [7:0] op, logic [7:0] len, logic [31:0] tx);
    logic [31:0] r;
    apb(1'h1, flash_pkg::REG_TX, tx, 1'h0, r);
    apb(1'h1, flash_pkg::REG_CTRL, {16'h0000, len, op}, 1'h0, r);
    repeat (4) @(posedge REF_CLK);
    apb(1'h0, flash_pkg::REG_STAT, 32'h0, 1'h0, r);
    while (r[flash_pkg::STAT_BUSY] !== 1'h0) apb(1'h0, flash_pkg::REG_STAT, 32'h0, 1'h0, r);
  endtask
  task automatic chk_rx(string nm, logic [7:0] e);
    logic [31:0] r;
    exp_q.push_back('{nm, {9'h000, 16'h0000, e}});
    apb(1'h0, flash_pkg::REG_RX, 32'h0, 1'h1, r);
  endtask
  task automatic fetch(string nm, logic [7:0] e);
    frame(flash_pkg::OP_STATUS_FETCH, 8'h03, 32'h0);
    chk_rx(nm, e);
  endtask
  task automatic fill(logic [16:0] a, logic [7:0] v);
    @(posedge REF_CLK);
    ARRAY_WE <= 1'h1; ARRAY_WADDR <= a; ARRAY_WDATA <= v;
    @(posedge REF_CLK);
    ARRAY_WE <= 1'h0;
  endtask
  task automatic settle();
    repeat (flash_pkg::STATUS_WRITE_CYC + 100) @(posedge REF_CLK);
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] r;
    void'($urandom(2032));
    repeat (12) @(posedge REF_CLK);
    RESET_N <= 1'h1;
    a0 = 8'($urandom);
    a1 = 8'($urandom);
    d = 8'($urandom) | 8'h84;
    st = {d[7], 2'h0, d[4:2], 2'h0};
    exp_q.push_back('{"unmapped", {1'h1, 32'h0}});
    apb(1'h0, 12'h020, 32'h0, 1'h1, r);
    exp_q.push_back('{"pins", 33'h000000001});
    apb(1'h0, flash_pkg::REG_PINS, 32'h0, 1'h1, r);
    fill(17'h1FFFF, ~a0); fill(17'h00000, a0); fill(17'h00001, a1);
    fetch("status_reset", 8'h00);
    $display("test registers done");
    frame(flash_pkg::OP_STATUS_STORE, 8'h02, {d, 24'h0});
    settle();
    fetch("store_no_latch", 8'h00);
    frame(flash_pkg::OP_WRITE_UNLOCK, 8'h01, 32'h0);
    fetch("latch_set", 8'h02);
    frame(flash_pkg::OP_STATUS_STORE, 8'h02, {d, 24'h0});
    fetch("busy_fetch", 8'h03);
    frame(flash_pkg::OP_ARRAY_READ, 8'h05, 32'h0);
    chk_rx("read_busy", 8'hFF);
    settle();
    fetch("store_done", st);
    cmp("status_word", {25'h0, st}, {25'h0, STATUS_WORD & 8'h9F});
    $display("test status store done");
    frame(flash_pkg::OP_WRITE_UNLOCK, 8'h01, 32'h0);
    frame(flash_pkg::OP_WIPE_A, 8'h01, 32'h0);
    cmp("erase_locked", 33'h0, 33'(erase_cnt));
    apb(1'h1, flash_pkg::REG_PINS, 32'h0, 1'h0, r);
    repeat (8) @(posedge REF_CLK);
    cmp("hw_lock", 33'h1, {32'h0, HW_LOCK});
    frame(flash_pkg::OP_WRITE_UNLOCK, 8'h01, 32'h0);
    frame(flash_pkg::OP_STATUS_STORE, 8'h02, 32'h0);
    settle();
    fetch("store_locked", st | 8'h02);
    apb(1'h1, flash_pkg::REG_PINS, 32'h1, 1'h0, r);
    repeat (8) @(posedge REF_CLK);
    cmp("hw_unlock", 33'h0, {32'h0, HW_LOCK});
    frame(flash_pkg::OP_STATUS_STORE, 8'h02, 32'h0);
    settle();
    fetch("store_clear", 8'h00);
    frame(flash_pkg::OP_WRITE_UNLOCK, 8'h01, 32'h0);
    frame(flash_pkg::OP_WRITE_LOCK, 8'h01, 32'h0);
    fetch("latch_clear", 8'h00);
    $display("test lock done");
    frame(flash_pkg::OP_WRITE_UNLOCK, 8'h01, 32'h0);
    frame(flash_pkg::OP_WIPE_B, 8'h01, 32'h0);
    cmp("erase_ok", 33'h1, 33'(erase_cnt));
    EXT_BUSY <= 1'h1;
    fetch("ext_busy", 8'h03);
    EXT_BUSY <= 1'h0;
    EXT_DONE <= 1'h1;
    @(posedge REF_CLK);
    EXT_DONE <= 1'h0;
    fetch("ext_done", 8'h00);
    $display("test erase done");
    frame(flash_pkg::OP_ARRAY_READ, 8'h05, 32'h01FFFF00);
    chk_rx("read_top", ~a0);
    frame(flash_pkg::OP_ARRAY_READ, 8'h06, 32'h01FFFF00);
    chk_rx("read_wrap", a0);
    frame(flash_pkg::OP_ARRAY_READ, 8'h07, 32'h01FFFF00);
    chk_rx("read_next", a1);
    $display("test array read done");
    frame(flash_pkg::OP_OTP_ENTER, 8'h01, 32'h0);
    cmp("otp_on", 33'h1, {32'h0, OTP_MODE});
    frame(flash_pkg::OP_WRITE_UNLOCK, 8'h01, 32'h0);
    frame(flash_pkg::OP_STATUS_STORE, 8'h02, 32'h0);
    settle();
    fetch("otp_seal", 8'h80);
    frame(flash_pkg::OP_WRITE_LOCK, 8'h01, 32'h0);
    cmp("otp_off", 33'h0, {32'h0, OTP_MODE});
    $display("test one-time sector done");
    give_verdict();
  end
endmodule
